// ==== rtl/cfg_reset_pkg.sv ====
// Constants for configuration select and reset control
package cfg_reset_pkg;

   // ****************************************************************
   // Clock and activity detector timing
   // ****************************************************************
   localparam int CLK_FREQ_MHZ     = 40;
   localparam int EDGE_RATE_MHZ    = 10;
   localparam int ASSERT_TIME_NS   = 2000;
   localparam int RELEASE_TIME_NS  = 500;
   localparam int ASSERT_CYCLES    = ASSERT_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int RELEASE_CYCLES   = RELEASE_TIME_NS * CLK_FREQ_MHZ / 1000;
   localparam int ASSERT_EDGES     = ASSERT_TIME_NS * EDGE_RATE_MHZ / 1000;
   localparam int RELEASE_EDGES    = RELEASE_TIME_NS * EDGE_RATE_MHZ / 1000;
   localparam int CNT_WIDTH        = 8;
   localparam int SYNC_STAGES      = 3;
   localparam int IDLE_LIMIT       = 2 * ASSERT_CYCLES + 2;

   // ****************************************************************
   // Global configuration map
   // ****************************************************************
   localparam int CFG_WIDTH        = 16;
   localparam int ADDR_WIDTH       = 3;
   localparam int NUM_GLOBAL       = 4;
   localparam logic [ADDR_WIDTH-1:0] CONFIG_KEY_FIRST_ADDR  = 3'h4;
   localparam logic [ADDR_WIDTH-1:0] CONFIG_KEY_SECOND_ADDR = 3'h5;
   localparam logic [CFG_WIDTH-1:0] KEY_FIRST_VALUE  = 16'hAC75;
   localparam logic [CFG_WIDTH-1:0] KEY_SECOND_VALUE = 16'h538A;
   localparam logic [2*CFG_WIDTH-1:0] KEY_COMPARE_VALUE =
      {KEY_SECOND_VALUE, KEY_FIRST_VALUE};
   localparam logic [CFG_WIDTH-1:0] KEY_RESET_VALUE = 16'h0000;
   // Hard-wired defaults, register 0 in the low word
   localparam logic [NUM_GLOBAL*CFG_WIDTH-1:0] GLOBAL_DEFAULTS =
      {16'h0040, 16'h01F4, 16'h0123, 16'h0010};

   // ****************************************************************
   // Pixel configuration and digital blocks
   // ****************************************************************
   localparam int PIX_NUM          = 8;
   localparam int PIX_AWIDTH       = 3;
   localparam int PIX_WIDTH        = 8;
   localparam logic [PIX_WIDTH-1:0] PIX_DEFAULT = 8'h00;
   localparam int NUM_BLOCKS       = 4;

   typedef enum logic [1:0] {
      GPO_POR,
      GPO_ACTIVITY,
      GPO_SELECT,
      GPO_ACCESS
   } gpo_sel_type;

endpackage : cfg_reset_pkg

// ==== rtl/reset_sync.sv ====
// Multi-stage level synchroniser for the activity reset
`timescale 1ns/1ps
module reset_sync
   import cfg_reset_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic d_i,
   output logic      q_o
);

   logic [SYNC_STAGES-1:0] stage_reg;

   // R12: low level means reset
   // Only the next stage ever reads stage 0
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         stage_reg <= '0;
      else
         stage_reg <= {stage_reg[SYNC_STAGES-2:0], d_i};
   end

   assign q_o = stage_reg[SYNC_STAGES-1];

endmodule : reset_sync

// ==== rtl/tmr_word.sv ====
// Triple redundant word with synchronous reset and majority vote
`timescale 1ns/1ps
module tmr_word
   import cfg_reset_pkg::*;
#(
   parameter logic [CFG_WIDTH-1:0] RESET_VAL = '0
)
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 we_i,
   input  wire logic [CFG_WIDTH-1:0] d_i,
   output logic      [CFG_WIDTH-1:0] q_o
);

   logic [CFG_WIDTH-1:0] copy_reg [3];
   logic [CFG_WIDTH-1:0] voted;

   assign voted = (copy_reg[0] & copy_reg[1]) |
                  (copy_reg[0] & copy_reg[2]) |
                  (copy_reg[1] & copy_reg[2]);

   // R13: synchronous reset only
   // Copies rewrite from the vote, so a single upset heals in a cycle
   always_ff @(posedge clk_i)
   begin
      for (int k = 0; k < 3; k++)
      begin
         if (!rst_n_i)
            copy_reg[k] <= RESET_VAL;
         else if (we_i)
            copy_reg[k] <= d_i;
         else
            copy_reg[k] <= voted;
      end
   end

   assign q_o = voted;

endmodule : tmr_word

// ==== rtl/config_select_and_reset_control.sv ====
// Configuration source selection and chip reset distribution
`timescale 1ns/1ps

// Operation
// R1: Start from hard-wired defaults, program same values
// R2: Per-register mux, hard-wired selected after start
// R3: Programmed registers resync to defaults when unselected
// R4: Pixel programmed storage has no reset
// R5: Key compare and activity reset drive selection
// R6: Key is AC75 then 538A
// R7: One flipped key bit still matches
// R8: Key registers clear to zero on clock
// R9: Global registers are triple redundant
// R10: Host writes key first, then registers
// R11: Selector glitch never corrupts stored values; code resets global programmed words while unselected
// R12: All resets active low
// R13: Digital block resets are synchronous only
// R14: Power-on reset only observed, resets nothing
// R15: Activity reset resets PLL, forces defaults
// R16: Global pulse triggers each block reset
// R17: Configuration access has its own reset
// R18: Reset below 10 MHz edge rate
// R19: Host idles line below 10 MHz to reset
// R20: About 2 us to assert, 0.5 us release
// R21: Activity reset returns PLL to acquisition
// R22: Host sends lock pattern for 1 ms
// R23: Activity reset synchronised before block resets
module config_select_and_reset_control
   import cfg_reset_pkg::*;
(
   input  wire logic                           clk_i,
   input  wire logic                           nrst_i,
   input  wire logic                           cmd_i,
   input  wire logic                           por_n_i,
   input  wire logic                           cfg_wr_i,
   input  wire logic [ADDR_WIDTH-1:0]          cfg_addr_i,
   input  wire logic [CFG_WIDTH-1:0]           cfg_wdata_i,
   input  wire logic                           pix_wr_i,
   input  wire logic [PIX_AWIDTH-1:0]          pix_addr_i,
   input  wire logic [PIX_WIDTH-1:0]           pix_wdata_i,
   input  wire logic                           gp_pulse_i,
   input  wire logic [NUM_BLOCKS-1:0]          gp_block_sel_i,
   input  wire logic                           gp_access_sel_i,
   input  wire logic [1:0]                     gpo_sel_i,
   output logic                                pll_reset_n_o,
   output logic                                cfg_select_prog_o,
   output logic [NUM_GLOBAL*CFG_WIDTH-1:0]     global_cfg_o,
   output logic [PIX_NUM*PIX_WIDTH-1:0]        pix_cfg_o,
   output logic [NUM_BLOCKS-1:0]               blk_rst_n_o,
   output logic                                config_access_reset_n_o,
   output logic                                gpo_o
);

   // ****************************************************************
   // Command activity detector
   // ****************************************************************
   logic                 cmd_q_reg;
   logic                 act_rst_n_reg;
   logic [CNT_WIDTH-1:0] win_cnt_reg;
   logic [CNT_WIDTH-1:0] edge_cnt_reg;
   logic                 rise;
   logic                 win_end;
   logic [CNT_WIDTH-1:0] win_len;

   assign rise = cmd_i & ~cmd_q_reg;
   // Long window while running, short window while held in reset
   assign win_len = act_rst_n_reg ? CNT_WIDTH'(ASSERT_CYCLES - 1)
                                  : CNT_WIDTH'(RELEASE_CYCLES - 1);
   assign win_end = (win_cnt_reg >= win_len);

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cmd_q_reg <= 1'b0;
      else
         cmd_q_reg <= cmd_i;
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         win_cnt_reg  <= '0;
         edge_cnt_reg <= '0;
      end
      else if (win_end)
      begin
         win_cnt_reg  <= '0;
         edge_cnt_reg <= '0;
      end
      else
      begin
         win_cnt_reg  <= win_cnt_reg + CNT_WIDTH'(1);
         edge_cnt_reg <= edge_cnt_reg + CNT_WIDTH'(rise);
      end
   end

   // R18: rate threshold decision
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         act_rst_n_reg <= 1'b0;
      else if (win_end && act_rst_n_reg &&
               (edge_cnt_reg < CNT_WIDTH'(ASSERT_EDGES)))
         act_rst_n_reg <= 1'b0;
      else if (win_end && !act_rst_n_reg &&
               (edge_cnt_reg >= CNT_WIDTH'(RELEASE_EDGES)))
         act_rst_n_reg <= 1'b1;
   end

   // R21: PLL back to acquisition
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         pll_reset_n_o <= 1'b0;
      else
         pll_reset_n_o <= act_rst_n_reg;
   end

   // ****************************************************************
   // Synchronous reset generation
   // ****************************************************************
   logic sync_rst_n;
   logic acc_rst_n_reg;

   // R23: synchronised activity reset
   reset_sync u_reset_sync (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .d_i    (act_rst_n_reg),
      .q_o    (sync_rst_n)
   );

   // R16: pulse or synchronised reset per block
   generate
      for (genvar b = 0; b < NUM_BLOCKS; b++)
      begin : g_blk
         always_ff @(posedge clk_i or negedge nrst_i)
         begin
            if (!nrst_i)
               blk_rst_n_o[b] <= 1'b0;
            else
               blk_rst_n_o[b] <= sync_rst_n &
                                 ~(gp_pulse_i & gp_block_sel_i[b]);
         end
      end
   endgenerate

   // R17: separate configuration access reset
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         acc_rst_n_reg <= 1'b0;
      else
         acc_rst_n_reg <= sync_rst_n & ~(gp_pulse_i & gp_access_sel_i);
   end

   assign config_access_reset_n_o = acc_rst_n_reg;

   // ****************************************************************
   // Key registers and comparator
   // ****************************************************************
   logic [CFG_WIDTH-1:0]   config_key_first;
   logic [CFG_WIDTH-1:0]   config_key_second;
   logic [2*CFG_WIDTH-1:0] key_diff;
   logic                   key_ok;
   logic                   sel_prog_reg;
   logic                   wr_ok;

   assign wr_ok = cfg_wr_i & acc_rst_n_reg;

   // R8: key cleared by the access reset
   // R9: triple redundant key storage
   tmr_word #(.RESET_VAL(KEY_RESET_VALUE)) u_key_first (
      .clk_i   (clk_i),
      .rst_n_i (acc_rst_n_reg),
      .we_i    (wr_ok && cfg_addr_i == CONFIG_KEY_FIRST_ADDR),
      .d_i     (cfg_wdata_i),
      .q_o     (config_key_first)
   );

   tmr_word #(.RESET_VAL(KEY_RESET_VALUE)) u_key_second (
      .clk_i   (clk_i),
      .rst_n_i (acc_rst_n_reg),
      .we_i    (wr_ok && cfg_addr_i == CONFIG_KEY_SECOND_ADDR),
      .d_i     (cfg_wdata_i),
      .q_o     (config_key_second)
   );

   // R6: fixed key compare
   assign key_diff = {config_key_second, config_key_first} ^
                     KEY_COMPARE_VALUE;
   // R7: zero or one differing bit
   assign key_ok = ((key_diff & (key_diff - 32'h00000001)) == '0);

   // R15: activity reset forces defaults
   logic rst_any_n;
   assign rst_any_n = nrst_i & act_rst_n_reg;

   // R5: selection register
   always_ff @(posedge clk_i or negedge rst_any_n)
   begin
      if (!rst_any_n)
         sel_prog_reg <= 1'b0;
      else
         sel_prog_reg <= key_ok;
   end

   assign cfg_select_prog_o = sel_prog_reg;

   // ****************************************************************
   // Global configuration registers and multiplexers
   // ****************************************************************
   logic [NUM_GLOBAL*CFG_WIDTH-1:0] global_prog;

   // R10: programmed writes only after switchover
   generate
      for (genvar g = 0; g < NUM_GLOBAL; g++)
      begin : g_glob
         // R3: resync to default when unselected
         tmr_word #(.RESET_VAL(GLOBAL_DEFAULTS[g*CFG_WIDTH +: CFG_WIDTH]))
            u_word (
            .clk_i   (clk_i),
            .rst_n_i (acc_rst_n_reg & sel_prog_reg),
            .we_i    (wr_ok && cfg_addr_i == ADDR_WIDTH'(g)),
            .d_i     (cfg_wdata_i),
            .q_o     (global_prog[g*CFG_WIDTH +: CFG_WIDTH])
         );
      end
   endgenerate

   // R1: defaults present as soon as reset is applied
   // R2: two-input source multiplexer
   always_ff @(posedge clk_i or negedge rst_any_n)
   begin
      if (!rst_any_n)
         global_cfg_o <= GLOBAL_DEFAULTS;
      else
         global_cfg_o <= sel_prog_reg ? global_prog : GLOBAL_DEFAULTS;
   end

   // ****************************************************************
   // Pixel configuration
   // ****************************************************************
   // R4: no reset on the pixel storage
   logic [PIX_WIDTH-1:0] pix_mem [PIX_NUM];

   always_ff @(posedge clk_i)
   begin
      if (pix_wr_i && acc_rst_n_reg)
         pix_mem[pix_addr_i] <= pix_wdata_i;
   end

   // R11: a selection change only steers the mux
   generate
      for (genvar p = 0; p < PIX_NUM; p++)
      begin : g_pix
         always_ff @(posedge clk_i or negedge rst_any_n)
         begin
            if (!rst_any_n)
               pix_cfg_o[p*PIX_WIDTH +: PIX_WIDTH] <= PIX_DEFAULT;
            else
               pix_cfg_o[p*PIX_WIDTH +: PIX_WIDTH] <=
                  sel_prog_reg ? pix_mem[p] : PIX_DEFAULT;
         end
      end
   endgenerate

   // ****************************************************************
   // General purpose observation output
   // ****************************************************************
   // R14: power-on reset only observed
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         gpo_o <= 1'b0;
      else
      begin
         case (gpo_sel_type'(gpo_sel_i))
            GPO_POR:      gpo_o <= por_n_i;
            GPO_ACTIVITY: gpo_o <= act_rst_n_reg;
            GPO_SELECT:   gpo_o <= sel_prog_reg;
            GPO_ACCESS:   gpo_o <= acc_rst_n_reg;
            default:      gpo_o <= 1'b0;
         endcase
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic [CNT_WIDTH-1:0] idle_cnt_reg;

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         idle_cnt_reg <= '0;
      else if (rise)
         idle_cnt_reg <= '0;
      else if (idle_cnt_reg != '1)
         idle_cnt_reg <= idle_cnt_reg + CNT_WIDTH'(1);
   end

   property p_idle_asserts;
      @(posedge clk_i) disable iff (!nrst_i)
      (idle_cnt_reg >= CNT_WIDTH'(IDLE_LIMIT)) |-> !act_rst_n_reg;
   endproperty
   a_idle_asserts: assert property (p_idle_asserts) // R20
      else $error("activity reset not asserted after idle line");

   property p_pll_follows;
      @(posedge clk_i) disable iff (!nrst_i)
      $fell(act_rst_n_reg) |-> ##[0:1] !pll_reset_n_o;
   endproperty
   a_pll_follows: assert property (p_pll_follows) // R21
      else $error("PLL reset did not follow activity reset");

   property p_sel_needs_key;
      @(posedge clk_i) disable iff (!nrst_i)
      sel_prog_reg |-> $past(key_ok) && act_rst_n_reg;
   endproperty
   a_sel_needs_key: assert property (p_sel_needs_key) // R5
      else $error("programmed source selected without key");

   property p_one_bit_key;
      @(posedge clk_i) disable iff (!nrst_i)
      ($countones(key_diff) <= 1 && act_rst_n_reg) ##1 act_rst_n_reg
      |-> sel_prog_reg;
   endproperty
   a_one_bit_key: assert property (p_one_bit_key) // R7
      else $error("key within one bit not accepted");

   property p_default_resync;
      @(posedge clk_i) disable iff (!nrst_i)
      !sel_prog_reg |=> global_prog == GLOBAL_DEFAULTS;
   endproperty
   a_default_resync: assert property (p_default_resync) // R3
      else $error("programmed values not reset to defaults");

   property p_key_cleared;
      @(posedge clk_i) disable iff (!nrst_i)
      !acc_rst_n_reg |=> {config_key_second, config_key_first} == '0;
   endproperty
   a_key_cleared: assert property (p_key_cleared) // R8
      else $error("key registers not cleared");

   property p_sync_reset;
      @(posedge clk_i) disable iff (!nrst_i)
      (!act_rst_n_reg) [*5] |-> blk_rst_n_o == '0 && !acc_rst_n_reg;
   endproperty
   a_sync_reset: assert property (p_sync_reset) // R23
      else $error("block resets missed synchronised reset");

   property p_pulse_block0;
      @(posedge clk_i) disable iff (!nrst_i)
      gp_pulse_i && gp_block_sel_i[0] |=> !blk_rst_n_o[0];
   endproperty
   a_pulse_block0: assert property (p_pulse_block0) // R16
      else $error("global pulse did not reset block");

   property p_access_own;
      @(posedge clk_i) disable iff (!nrst_i)
      gp_pulse_i && gp_access_sel_i && !gp_block_sel_i[0] && sync_rst_n
      |=> !acc_rst_n_reg && blk_rst_n_o[0];
   endproperty
   a_access_own: assert property (p_access_own) // R17
      else $error("access reset not independent");

endmodule : config_select_and_reset_control

// ==== verification/cmd_line_model.sv ====
// Readout side model that drives the serial command line
`timescale 1ns/1ps
module cmd_line_model
(
   input  wire logic       clk_i,
   input  wire logic [1:0] mode_i,
   output logic            cmd_o
);
   // ****************************************************************
   // Line pattern
   // ****************************************************************
   logic [5:0] slow_cnt_reg;

   initial cmd_o = 1'b0;
   initial slow_cnt_reg = 6'h00;

   // idle or lock stream
   // Toggling every cycle is the fastest edge rate a 40 MHz sampler sees
   always @(posedge clk_i)
   begin
      slow_cnt_reg <= slow_cnt_reg + 6'h01;
      case (mode_i)
         2'h1:    cmd_o <= #2 (slow_cnt_reg == 6'h00);
         2'h2:    cmd_o <= #2 ~cmd_o;
         default: cmd_o <= #2 1'b0;
      endcase
   end
endmodule : cmd_line_model

// ==== verification/config_select_and_reset_control_tb.sv ====
// Self-checking bench for configuration select and reset control
`timescale 1ns/1ps
module config_select_and_reset_control_tb
   import cfg_reset_pkg::*;
();
   // ****************************************************************
   // Signals
   // ****************************************************************
   logic                          clk_i;
   logic                          nrst_i;
   logic                          cmd_i;
   logic                          por_n_i;
   logic                          cfg_wr_i;
   logic [ADDR_WIDTH-1:0]         cfg_addr_i;
   logic [CFG_WIDTH-1:0]          cfg_wdata_i;
   logic                          pix_wr_i;
   logic [PIX_AWIDTH-1:0]         pix_addr_i;
   logic [PIX_WIDTH-1:0]          pix_wdata_i;
   logic                          gp_pulse_i;
   logic [NUM_BLOCKS-1:0]         gp_block_sel_i;
   logic                          gp_access_sel_i;
   logic [1:0]                    gpo_sel_i;
   logic [1:0]                    mode;
   logic                          pll_reset_n_o;
   logic                          cfg_select_prog_o;
   logic [NUM_GLOBAL*CFG_WIDTH-1:0] global_cfg_o;
   logic [PIX_NUM*PIX_WIDTH-1:0]  pix_cfg_o;
   logic [NUM_BLOCKS-1:0]         blk_rst_n_o;
   logic                          config_access_reset_n_o;
   logic                          gpo_o;
   int                            bad_count = 0;
   int                            cmp_count = 0;

   config_select_and_reset_control config_select_and_reset_control_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .cmd_i(cmd_i), .por_n_i(por_n_i),
      .cfg_wr_i(cfg_wr_i), .cfg_addr_i(cfg_addr_i),
      .cfg_wdata_i(cfg_wdata_i), .pix_wr_i(pix_wr_i),
      .pix_addr_i(pix_addr_i), .pix_wdata_i(pix_wdata_i),
      .gp_pulse_i(gp_pulse_i), .gp_block_sel_i(gp_block_sel_i),
      .gp_access_sel_i(gp_access_sel_i), .gpo_sel_i(gpo_sel_i),
      .pll_reset_n_o(pll_reset_n_o), .cfg_select_prog_o(cfg_select_prog_o),
      .global_cfg_o(global_cfg_o), .pix_cfg_o(pix_cfg_o),
      .blk_rst_n_o(blk_rst_n_o),
      .config_access_reset_n_o(config_access_reset_n_o), .gpo_o(gpo_o));

   cmd_line_model cmd_line_model_inst (
      .clk_i(clk_i), .mode_i(mode), .cmd_o(cmd_i));

   initial clk_i = 1'b0;
   always #12.5 clk_i = ~clk_i;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask : tick

   task automatic check_flag(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_flag

   task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_word

   task automatic give_verdict;
      $display("cmp_count=%0d bad_count=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   task automatic cfg_write(input logic [2:0] a, input logic [15:0] d);
      cfg_wr_i = 1'b1;
      cfg_addr_i = a;
      cfg_wdata_i = d;
      tick(1);
      cfg_wr_i = 1'b0;
      tick(1);
   endtask : cfg_write

   // Both halves back to back, selection judged two edges after the last
   task automatic write_key(input logic [31:0] k, input logic exp_sel);
      cfg_wr_i = 1'b1;
      cfg_addr_i = CONFIG_KEY_FIRST_ADDR;
      cfg_wdata_i = k[15:0];
      tick(1);
      cfg_addr_i = CONFIG_KEY_SECOND_ADDR;
      cfg_wdata_i = k[31:16];
      tick(1);
      cfg_wr_i = 1'b0;
      tick(2);
      check_flag(cfg_select_prog_o, exp_sel);
   endtask : write_key

   task automatic wait_ready;
      for (int i = 0; i < 300; i++)
         if (blk_rst_n_o !== 4'hF || config_access_reset_n_o !== 1'b1)
            tick(1);
      check_word({60'h0, blk_rst_n_o}, 64'hF);
      check_flag(pll_reset_n_o, 1'b1);
   endtask : wait_ready

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic test_startup;
      wait_ready();
      check_flag(cfg_select_prog_o, 1'b0);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
      check_word(pix_cfg_o, {PIX_NUM{PIX_DEFAULT}});
   endtask : test_startup

   task automatic test_key_select;
      logic [63:0] exp;
      logic [63:0] pexp;
      exp = GLOBAL_DEFAULTS;
      pexp = {PIX_NUM{PIX_DEFAULT}};
      cfg_write(3'h0, 16'h1234);
      tick(1);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
      write_key(KEY_COMPARE_VALUE, 1'b1);
      tick(1);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
      cfg_write(3'h1, 16'hBEEF);
      exp[31:16] = 16'hBEEF;
      check_word(global_cfg_o, exp);
      cfg_write(3'h6, 16'hFFFF);
      check_word(global_cfg_o, exp);
      pix_wr_i = 1'b1;
      pix_addr_i = 3'h3;
      pix_wdata_i = 8'hA5;
      tick(1);
      pix_wr_i = 1'b0;
      tick(2);
      pexp[31:24] = 8'hA5;
      check_word(pix_cfg_o, pexp);
   endtask : test_key_select

   task automatic test_bit_flip;
      logic [63:0] exp;
      exp = GLOBAL_DEFAULTS;
      exp[31:16] = 16'hBEEF;
      for (int k = 0; k < 32; k++)
         write_key(KEY_COMPARE_VALUE ^ (32'h1 << k), 1'b1);
      check_word(global_cfg_o, exp);
      write_key(KEY_COMPARE_VALUE ^ 32'h3, 1'b0);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
      write_key(KEY_COMPARE_VALUE, 1'b1);
      tick(1);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
   endtask : test_bit_flip

   task automatic test_gpo;
      por_n_i = 1'b0;
      gpo_sel_i = GPO_POR;
      tick(2);
      check_flag(gpo_o, 1'b0);
      check_word({60'h0, blk_rst_n_o}, 64'hF);
      check_flag(cfg_select_prog_o, 1'b1);
      por_n_i = 1'b1;
      tick(2);
      check_flag(gpo_o, 1'b1);
      gpo_sel_i = GPO_ACTIVITY;
      tick(2);
      check_flag(gpo_o, 1'b1);
      gpo_sel_i = GPO_SELECT;
      tick(2);
      check_flag(gpo_o, 1'b1);
      gpo_sel_i = GPO_ACCESS;
      tick(2);
      check_flag(gpo_o, 1'b1);
   endtask : test_gpo

   task automatic pulse(input logic [3:0] sel, input logic acc);
      logic [3:0] low_seen;
      logic       acc_seen;
      gp_pulse_i = 1'b1;
      gp_block_sel_i = sel;
      gp_access_sel_i = acc;
      tick(1);
      gp_pulse_i = 1'b0;
      low_seen = ~blk_rst_n_o;
      acc_seen = ~config_access_reset_n_o;
      tick(1);
      low_seen = low_seen | ~blk_rst_n_o;
      acc_seen = acc_seen | ~config_access_reset_n_o;
      tick(1);
      check_word({60'h0, low_seen}, {60'h0, sel});
      check_flag(acc_seen, acc);
      check_word({60'h0, blk_rst_n_o}, 64'hF);
   endtask : pulse

   task automatic test_pulse;
      for (int b = 0; b < NUM_BLOCKS; b++)
         pulse(4'h1 << b, 1'b0);
      check_flag(cfg_select_prog_o, 1'b1);
      pulse(4'h0, 1'b1);
      tick(2);
      check_flag(cfg_select_prog_o, 1'b0);
   endtask : test_pulse

   task automatic test_idle;
      int n;
      write_key(KEY_COMPARE_VALUE, 1'b1);
      mode = 2'h1;
      for (int i = 0; i < 300; i++)
         if (pll_reset_n_o !== 1'b0)
            tick(1);
      check_flag(pll_reset_n_o, 1'b0);
      check_word({60'h0, blk_rst_n_o}, 64'hF);
      check_flag(cfg_select_prog_o, 1'b0);
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
      tick(6);
      check_word({60'h0, blk_rst_n_o}, 64'h0);
      // A steady low line is the other idle form
      mode = 2'h0;
      tick(200);
      check_flag(pll_reset_n_o, 1'b0);
      check_word({60'h0, blk_rst_n_o}, 64'h0);
      mode = 2'h2;
      n = 0;
      while (pll_reset_n_o !== 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
      check_flag(n <= 2 * RELEASE_CYCLES + 2, 1'b1);
      wait_ready();
      check_flag(cfg_select_prog_o, 1'b0);
      write_key(KEY_COMPARE_VALUE, 1'b1);
      tick(1);
      check_word(pix_cfg_o, {{4{PIX_DEFAULT}}, 8'hA5, {3{PIX_DEFAULT}}});
      check_word(global_cfg_o, GLOBAL_DEFAULTS);
   endtask : test_idle

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      nrst_i = 1'b0;
      por_n_i = 1'b1;
      cfg_wr_i = 1'b0;
      cfg_addr_i = 3'h0;
      cfg_wdata_i = 16'h0000;
      pix_wr_i = 1'b0;
      pix_addr_i = 3'h0;
      pix_wdata_i = 8'h00;
      gp_pulse_i = 1'b0;
      gp_block_sel_i = 4'h0;
      gp_access_sel_i = 1'b0;
      gpo_sel_i = 2'h0;
      mode = 2'h2;
      tick(5);
      nrst_i = 1'b1;
      test_startup();
      test_key_select();
      test_bit_flip();
      test_gpo();
      test_pulse();
      test_idle();
      give_verdict();
   end

   // Whole run needs under 2000 cycles
   initial
   begin
      #100us;
      bad_count++;
      give_verdict();
   end
endmodule : config_select_and_reset_control_tb
